// ==== hw/epc_cond_check.sv ====
// Power condition lookup and timer clamp
`timescale 1ns/1ps
`include "epc_regs.svh"
module epc_cond_check (
  // Request fields
  input  wire logic [7:0]  condId,
  input  wire logic [15:0] timerIn,
  input  wire logic        minutes,
  // Lookup results
  output logic [1:0]  idx,
  output logic        supported,
  output logic        changeable,
  output logic        savable,
  output logic [23:0] timerClamped
);

  localparam logic [25:0] MinuteRatio = 26'(`EPC_MINUTE_MS / `EPC_UNIT_MS);

  function automatic logic [23:0] clampTimer(input logic [15:0] t, input logic m);
    logic [25:0] scaled;
    scaled = m ? {10'h000, t} * MinuteRatio : {10'h000, t};
    if (scaled > {2'b00, `EPC_TIMER_MAX}) begin
      clampTimer = `EPC_TIMER_MAX;
    end else if (scaled < {2'b00, `EPC_TIMER_MIN}) begin
      clampTimer = `EPC_TIMER_MIN;
    end else begin
      clampTimer = scaled[23:0];
    end
  endfunction

  always_comb begin
    supported = 1'b1;
    idx       = 2'd0;
    if (condId == `EPC_ID_0) begin
      idx = 2'd0;
    end else if (condId == `EPC_ID_1) begin
      idx = 2'd1;
    end else if (condId == `EPC_ID_2) begin
      idx = 2'd2;
    end else if (condId == `EPC_ID_3) begin
      idx = 2'd3;
    end else begin
      supported = 1'b0;
    end
    changeable   = supported && ((`EPC_CHANGEABLE >> idx) & 4'h1) != 4'h0;
    savable      = supported && ((`EPC_SAVABLE >> idx) & 4'h1) != 4'h0;
    timerClamped = clampTimer(timerIn, minutes);
  end

endmodule // epc_cond_check

// ==== hw/epc_device.sv ====
// Device end: decodes and executes the power-condition subcommands
//
// Contract
// - Subcommand 1h selects go-to condition
// - Subcommand 2h selects set condition timer
// - Host puts condition identifier in sector count
// - Successful go-to halts all enabled timers
// - Enter condition right after completion
// - Stay there until next command or reset
// - Abort go-to: FFh, unsupported, feature disabled
// - Timer load takes cylinder high/low value
// - Timer enabled only if enable and nonzero
// - Save bit copies current into saved fields
// - Bit 7 picks 100 ms or minute units
// - Bit 5 enable, bit 4 save
// - Clamp out-of-range timer to limits
// - Maximum 3BFFC4h in 100 ms, minimum zero
// - Abort timer: unchangeable, unsupported, disabled, unsavable
// - Aborted timer request changes nothing
// - Set-state enables timer per enable bit
// - Set-state with save copies enabled flag
// - Subcommand 3h selects set condition state
// - Set-state abort on unsavable save; no change
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "epc_regs.svh"
module epc_device (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Command block link
  epc_link_if.dev           link,
  // Feature state from the rest of the device
  input  wire logic         epcEnabled,
  // Power condition state
  output logic              inPowerCond,
  output logic [7:0]        powerCondId,
  output logic [3:0]        timerRun,
  output logic [3:0]        curEnable,
  output logic [3:0]        savEnable,
  output logic [3:0][23:0]  curTimers,
  output logic [3:0][23:0]  savTimers
);

  epc_pkg::dev_regs_type r_q;
  epc_pkg::dev_regs_type r_d;

  logic [1:0]  idx;
  logic        supported;
  logic        changeable;
  logic        savable;
  logic [23:0] timerClamped;

  epc_cond_check i_epc_cond_check (
    .condId       (link.secCount),
    .timerIn      ({link.cylHigh, link.cylLow}),
    .minutes      (link.secNumber[`EPC_SN_UNITS]),
    .idx          (idx),
    .supported    (supported),
    .changeable   (changeable),
    .savable      (savable),
    .timerClamped (timerClamped)
  );

  function automatic logic [7:0] okStatus();
    logic [7:0] s;
    s = 8'h00;
    s[`EPC_ST_RDY] = 1'b1;
    okStatus = s;
  endfunction

  logic [3:0] sub;
  logic       enReq;
  logic       saveReq;
  logic       isEpc;
  logic       abortCmd;

  always_comb begin
    r_d      = r_q;
    r_d.done = 1'b0;
    sub      = link.secNumber[3:0];
    enReq    = link.secNumber[`EPC_SN_ENABLE];
    saveReq  = link.secNumber[`EPC_SN_SAVE];
    isEpc    = link.command == `EPC_CMD_SET_FEATURES && link.feature == `EPC_FEAT_EPC;
    abortCmd = 1'b0;

    case (r_q.st)
      epc_pkg::DevIdle: begin
        if (link.cmdWrite) begin
          // any new command ends the entered condition
          r_d.inCond = 1'b0;
          r_d.goPend = 1'b0;
          r_d.status = 8'h00;
          r_d.status[`EPC_ST_BSY] = 1'b1;
          r_d.error  = 8'h00;
          r_d.st     = epc_pkg::DevExec;
        end
      end

      epc_pkg::DevExec: begin
        // Parameters are sampled here; the host holds them while busy
        if (!isEpc) begin
          abortCmd = link.command == `EPC_CMD_SET_FEATURES;
        end else if (sub == `EPC_SUB_GOTO) begin
          if (link.secCount == `EPC_ID_ALL || !supported || !epcEnabled) begin
            abortCmd = 1'b1;
          end else begin
            r_d.goPend = 1'b1;
            r_d.condId = link.secCount;
          end
        end else if (sub == `EPC_SUB_TIMER) begin
          if (!supported || !changeable || !epcEnabled || (saveReq && !savable)) begin
            abortCmd = 1'b1;
          end else begin
            r_d.curTimer[idx] = timerClamped;
            // enabled only with a nonzero value
            r_d.curEn[idx]    = enReq && timerClamped != 24'h000000;
            if (saveReq && savable) begin
              r_d.savTimer[idx] = timerClamped;
              r_d.savEn[idx]    = r_d.curEn[idx];
            end
          end
        end else if (sub == `EPC_SUB_STATE) begin
          if (!supported || !changeable || !epcEnabled || (saveReq && !savable)) begin
            abortCmd = 1'b1;
          end else begin
            r_d.curEn[idx] = enReq;
            if (saveReq) begin
              r_d.savEn[idx] = enReq;
            end
          end
        end else begin
          // Restore, feature enable/disable and any other subcommand are aborted here
          abortCmd = 1'b1;
        end

        r_d.status = okStatus();
        // an abort leaves all settings as they were
        if (abortCmd) begin
          r_d.curTimer = r_q.curTimer;
          r_d.savTimer = r_q.savTimer;
          r_d.curEn    = r_q.curEn;
          r_d.savEn    = r_q.savEn;
          r_d.goPend   = 1'b0;
          r_d.error[`EPC_ER_ABT]  = 1'b1;
          r_d.status[`EPC_ST_ERR] = 1'b1;
        end
        r_d.done = 1'b1;
        r_d.st   = r_d.goPend ? epc_pkg::DevEnter : epc_pkg::DevIdle;
      end

      epc_pkg::DevEnter: begin
        // enter the condition once completion is reported
        r_d.inCond = 1'b1;
        r_d.goPend = 1'b0;
        r_d.st     = epc_pkg::DevIdle;
        if (link.cmdWrite) begin
          // a command arriving here still wins
          r_d.inCond = 1'b0;
          r_d.status = 8'h00;
          r_d.status[`EPC_ST_BSY] = 1'b1;
          r_d.error  = 8'h00;
          r_d.st     = epc_pkg::DevExec;
        end
      end

      default: begin
        r_d.st = epc_pkg::DevIdle;
      end
    endcase

    // timers stand still while a go-to condition is held
    r_d.timerRun = (r_d.inCond || r_d.goPend) ? 4'h0 : r_d.curEn;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      r_q.st       <= epc_pkg::DevIdle;
      r_q.inCond   <= 1'b0;
      r_q.goPend   <= 1'b0;
      r_q.condId   <= 8'h00;
      r_q.status   <= `EPC_STATUS_RESET;
      r_q.error    <= 8'h00;
      r_q.done     <= 1'b0;
      r_q.curTimer <= {4{`EPC_TIMER_RESET}};
      r_q.savTimer <= {4{`EPC_TIMER_RESET}};
      r_q.curEn    <= 4'h0;
      r_q.savEn    <= 4'h0;
      r_q.timerRun <= 4'h0;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from the state register
  assign link.ataStatus = r_q.status;
  assign link.ataError  = r_q.error;
  assign link.cmdDone   = r_q.done;
  assign inPowerCond    = r_q.inCond;
  assign powerCondId    = r_q.condId;
  assign timerRun       = r_q.timerRun;
  assign curEnable      = r_q.curEn;
  assign savEnable      = r_q.savEn;
  assign curTimers      = r_q.curTimer;
  assign savTimers      = r_q.savTimer;

endmodule // epc_device

// ==== hw/epc_host.sv ====
// Host end: APB registers drive the command block link
`timescale 1ns/1ps
`include "epc_regs.svh"
module epc_host (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Command block link
  epc_link_if.host         link
);

  epc_pkg::host_regs_type r_q;
  epc_pkg::host_regs_type r_d;

  logic access;
  logic wrStart;

  always_comb begin
    r_d          = r_q;
    r_d.cmdWrite = 1'b0;
    r_d.pready   = 1'b0;
    r_d.pslverr  = 1'b0;
    wrStart      = 1'b0;
    // One wait state: answer on the second access cycle
    access       = psel && penable && !r_q.pready;

    if (access) begin
      r_d.pready = 1'b1;
      r_d.prdata = 32'h00000000;
      if (paddr == `EPC_APB_PARAM) begin
        r_d.prdata = r_q.param;
      end else if (paddr == `EPC_APB_CTRL) begin
        r_d.prdata = {16'h0000, r_q.feature, r_q.command};
      end else if (paddr == `EPC_APB_STAT) begin
        r_d.prdata = {8'h00, r_q.ataError, r_q.ataStatus, 6'h00, r_q.doneSticky,
                      r_q.st != epc_pkg::HostIdle};
      end else begin
        r_d.pslverr = 1'b1;
      end
    end

    // Writes land only at the edge where the master sees pready
    if (psel && penable && pwrite && r_q.pready && r_q.st == epc_pkg::HostIdle) begin
      if (paddr == `EPC_APB_PARAM) begin
        r_d.param = pwdata;
      end else if (paddr == `EPC_APB_CTRL) begin
        r_d.command = pwdata[7:0];
        r_d.feature = pwdata[15:8];
        wrStart     = pwdata[`EPC_CTRL_START];
      end
    end

    case (r_q.st)
      epc_pkg::HostIdle: begin
        if (wrStart) begin
          r_d.doneSticky = 1'b0;
          r_d.st         = epc_pkg::HostLoad;
        end
      end
      epc_pkg::HostLoad: begin
        // parameters and command code settle a cycle before cmdWrite
        r_d.cmdWrite = 1'b1;
        r_d.st       = epc_pkg::HostIssue;
      end
      epc_pkg::HostIssue: begin
        r_d.st = epc_pkg::HostWait;
      end
      epc_pkg::HostWait: begin
        if (link.cmdDone) begin
          r_d.doneSticky = 1'b1;
          r_d.ataStatus  = link.ataStatus;
          r_d.ataError   = link.ataError;
          r_d.st         = epc_pkg::HostIdle;
        end
      end
      default: begin
        r_d.st = epc_pkg::HostIdle;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign link.secCount  = r_q.param[7:0];
  assign link.secNumber = r_q.param[15:8];
  assign link.cylLow    = r_q.param[23:16];
  assign link.cylHigh   = r_q.param[31:24];
  assign link.command   = r_q.command;
  assign link.feature   = r_q.feature;
  assign link.cmdWrite  = r_q.cmdWrite;
  assign pready         = r_q.pready;
  assign pslverr        = r_q.pslverr;
  assign prdata         = r_q.prdata;

endmodule // epc_host

// ==== hw/epc_link_if.sv ====
// Command block link between host end and device end
`timescale 1ns/1ps
interface epc_link_if;
  // Host to device
  logic [7:0] feature;
  logic [7:0] secCount;
  logic [7:0] secNumber;
  logic [7:0] cylLow;
  logic [7:0] cylHigh;
  logic [7:0] command;
  logic       cmdWrite;
  // Device to host
  logic [7:0] ataStatus;
  logic [7:0] ataError;
  logic       cmdDone;

  modport dev (
    input  feature, secCount, secNumber, cylLow, cylHigh, command, cmdWrite,
    output ataStatus, ataError, cmdDone
  );
  modport host (
    output feature, secCount, secNumber, cylLow, cylHigh, command, cmdWrite,
    input  ataStatus, ataError, cmdDone
  );
endinterface

// ==== hw/epc_pkg.sv ====
// Types shared by the power-condition handler and its host end
package epc_pkg;

  typedef enum logic [1:0] {DevIdle, DevExec, DevEnter} dev_state_type;
  typedef enum logic [1:0] {HostIdle, HostLoad, HostIssue, HostWait} host_state_type;

  typedef struct packed {
    dev_state_type    st;
    logic             inCond;
    logic             goPend;
    logic [7:0]       condId;
    logic [7:0]       status;
    logic [7:0]       error;
    logic             done;
    logic [3:0][23:0] curTimer;
    logic [3:0][23:0] savTimer;
    logic [3:0]       curEn;
    logic [3:0]       savEn;
    logic [3:0]       timerRun;
  } dev_regs_type;

  typedef struct packed {
    host_state_type st;
    logic [31:0]    param;
    logic [7:0]     command;
    logic [7:0]     feature;
    logic           cmdWrite;
    logic           doneSticky;
    logic [7:0]     ataStatus;
    logic [7:0]     ataError;
    logic           pready;
    logic           pslverr;
    logic [31:0]    prdata;
  } host_regs_type;

endpackage

// ==== hw/epc_regs.svh ====
// Constants for the power-condition subcommand handler and its host end
`ifndef EPC_REGS_SVH
`define EPC_REGS_SVH

// Command block codes
`define EPC_CMD_SET_FEATURES 8'hef
`define EPC_FEAT_EPC         8'h4a
`define EPC_SUB_GOTO         4'h1
`define EPC_SUB_TIMER        4'h2
`define EPC_SUB_STATE        4'h3
`define EPC_ID_ALL           8'hff

// Power condition identifiers, one per table slot
`define EPC_ID_0             8'h00
`define EPC_ID_1             8'h01
`define EPC_ID_2             8'h81
`define EPC_ID_3             8'h82
`define EPC_CHANGEABLE       4'hf
`define EPC_SAVABLE          4'h7
`define EPC_NUM_COND         4

// Sector number fields
`define EPC_SN_UNITS         7
`define EPC_SN_ENABLE        5
`define EPC_SN_SAVE          4

// Timer units in ms, limits in 100 ms units
`define EPC_UNIT_MS          100
`define EPC_MINUTE_MS        60000
`define EPC_TIMER_MAX        24'h3bffc4
`define EPC_TIMER_MIN        24'h000000
`define EPC_TIMER_RESET      24'h000000

// Status and error bits
`define EPC_ST_BSY           7
`define EPC_ST_RDY           6
`define EPC_ST_DF            5
`define EPC_ST_ERR           0
`define EPC_ER_ABT           2
`define EPC_STATUS_RESET     8'h40

// Host APB register map
`define EPC_APB_PARAM        12'h000
`define EPC_APB_CTRL         12'h004
`define EPC_APB_STAT         12'h008
`define EPC_CTRL_START       31

`endif

// ==== verif/epc_asserts.sv ====
// Link protocol checks between host end and device end
`timescale 1ns/1ps
module epc_asserts (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rstn,
  // Host to device
  input wire logic [7:0] command,
  input wire logic [7:0] feature,
  input wire logic [7:0] secCount,
  input wire logic [7:0] secNumber,
  input wire logic       cmdWrite,
  // Device to host
  input wire logic [7:0] ataStatus,
  input wire logic [7:0] ataError,
  input wire logic       cmdDone
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_epc;
    cmdWrite && command == 8'hef && feature == 8'h4a;
  endsequence
  sequence s_abt;
    ##2 cmdDone && ataStatus == 8'h41 && ataError == 8'h04;
  endsequence

  a_done_two: assert property (cmdWrite |=> !cmdDone ##1 cmdDone)
    else $error("completion not two cycles after start");
  a_busy_exec: assert property (cmdWrite |=> ataStatus == 8'h80)
    else $error("busy not shown during execution");
  a_done_pulse: assert property (cmdDone |=> !cmdDone)
    else $error("completion longer than one cycle");
  a_abort_flags: assert property (cmdDone && ataStatus[0] |-> ataStatus == 8'h41
    && ataError == 8'h04)
    else $error("abort status or error wrong");
  a_ok_clean: assert property (cmdDone && !ataStatus[0] |-> ataStatus == 8'h40
    && ataError == 8'h00)
    else $error("good completion not clean");
  a_goto_all: assert property (s_epc ##0 (secNumber[3:0] == 4'h1
    && secCount == 8'hff) |-> s_abt)
    else $error("go-to with all id not aborted");
  a_sub_range: assert property (s_epc ##0 (secNumber[3:0] == 4'h0
    || secNumber[3:0] > 4'h3) |-> s_abt)
    else $error("unknown subcommand not aborted");
  a_status_stand: assert property (!cmdWrite ##1 !cmdDone |-> $stable(ataStatus)
    && $stable(ataError))
    else $error("status changed between commands");
  a_args_hold: assert property (cmdWrite |=> !cmdWrite && $stable(secCount)
    && $stable(secNumber) && $stable(command))
    else $error("parameters moved during execution");
  a_other_cmd: assert property (cmdWrite && command != 8'hef |-> ##2
    ataStatus == 8'h40)
    else $error("other command not completed cleanly");
endmodule // epc_asserts

// ==== verif/power_condition_subcommands_tb.sv ====
// Self-checking bench for the host end and device end pair
`timescale 1ns/1ps
module power_condition_subcommands_tb;
  typedef struct {
    logic [7:0]       st;
    logic [7:0]       er;
    logic [3:0][23:0] ct;
    logic [3:0][23:0] svt;
    logic [3:0]       ce;
    logic [3:0]       se;
    logic             go;
    logic [7:0]       gid;
  } note_type;
  logic             core_clk = 0;
  logic             rstn = 0;
  logic             psel = 0;
  logic             penable = 0;
  logic             pwrite = 0;
  logic [11:0]      paddr = '0;
  logic [31:0]      pwdata = '0;
  logic             epcEnabled = 1;
  logic             pready, pslverr, inPowerCond;
  logic [31:0]      prdata;
  logic [7:0]       powerCondId;
  logic [3:0]       timerRun, curEnable, savEnable;
  logic [3:0][23:0] curTimers, savTimers, mCt, mSt;
  logic [3:0]       mCe, mSe;
  logic [15:0]      lfsr = 16'h0059;
  logic [7:0]       ids [4] = '{8'h00, 8'h01, 8'h81, 8'h82};
  note_type         noteQ [$];
  int               bad_count = 0;
  int               tests_run = 0;

  epc_link_if link ();
  epc_host i_epc_host (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata, .link);
  epc_device i_epc_device (.core_clk, .rstn, .link, .epcEnabled, .inPowerCond,
    .powerCondId, .timerRun, .curEnable, .savEnable, .curTimers, .savTimers);
  epc_asserts i_epc_asserts (.core_clk, .rstn, .command(link.command),
    .feature(link.feature), .secCount(link.secCount), .secNumber(link.secNumber),
    .cmdWrite(link.cmdWrite), .ataStatus(link.ataStatus), .ataError(link.ataError),
    .cmdDone(link.cmdDone));

  always #12.5 core_clk = ~core_clk;

  task automatic check(string what, logic [95:0] seen, logic [95:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] nextLfsr(logic [15:0] v);
    nextLfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Predicts the outcome, notes it, then issues the command over APB
  task automatic runCmd(logic [7:0] cmd, logic [7:0] feat, logic [7:0] sc,
                        logic [7:0] sn, logic [15:0] tv);
    note_type n;
    logic [31:0] r;
    logic e;
    logic [1:0] s;
    logic [25:0] t;
    int k;
    s = sc == 8'h01 ? 2'd1 : sc == 8'h81 ? 2'd2 : sc == 8'h82 ? 2'd3 : 2'd0;
    t = sn[7] ? tv * 600 : tv;
    if (t > 26'h3bffc4)
      t = 26'h3bffc4;
    n.st = 8'h40;
    n.go = 0;
    n.gid = sc;
    if (cmd == 8'hef) begin
      if (feat != 8'h4a || !epcEnabled || !(sc inside {ids}) || sn[3:0] == 0
          || sn[3:0] > 3 || (sn[3:0] != 1 && sn[4] && s == 3))
        n.st = 8'h41;
      else if (sn[3:0] == 1)
        n.go = 1;
      else begin
        if (sn[3:0] == 2) begin
          mCt[s] = t[23:0];
          mCe[s] = sn[5] && t != 0;
        end else
          mCe[s] = sn[5];
        if (sn[4]) begin
          mSe[s] = mCe[s];
          if (sn[3:0] == 2)
            mSt[s] = mCt[s];
        end
      end
    end
    n.er = n.st[0] ? 8'h04 : 8'h00;
    n.ct = mCt;
    n.svt = mSt;
    n.ce = mCe;
    n.se = mSe;
    noteQ.push_back(n);
    apb(1, 12'h000, {tv, sn, sc}, r, e);
    apb(1, 12'h004, {1'b1, 15'h0, feat, cmd}, r, e);
    k = 0;
    do begin
      apb(0, 12'h008, 32'h0, r, e);
      k++;
    end while (r[1] !== 1'b1 && k < 20);
    check("host done", r[1:0], 2'b10);
    check("host status", r[15:8], n.st);
    check("host error", r[23:16], n.er);
  endtask

  // Result watcher: takes the oldest note at each completion
  initial forever begin
    note_type n;
    @(negedge core_clk);
    if (link.cmdDone === 1'b1) begin
      check("note queued", noteQ.size() != 0, 1);
      n = noteQ.pop_front();
      check("status", link.ataStatus, n.st);
      check("error", link.ataError, n.er);
      check("cur timers", curTimers, n.ct);
      check("sav timers", savTimers, n.svt);
      check("cur enable", curEnable, n.ce);
      check("sav enable", savEnable, n.se);
      check("left cond", inPowerCond, 0);
      @(negedge core_clk);
      check("in cond", inPowerCond, n.go);
      check("timers run", timerRun, n.go ? 4'h0 : n.ce);
      if (n.go)
        check("cond id", powerCondId, n.gid);
    end
  end

  // Watchdog, well beyond the expected run
  initial begin
    #150us;
    bad_count++;
    complete_run();
  end

  initial begin
    logic [31:0] r;
    logic e;
    mCt = '0;
    mSt = '0;
    mCe = '0;
    mSe = '0;
    repeat (6) @(posedge core_clk);
    rstn <= 1;
    @(negedge core_clk);
    check("reset status", link.ataStatus, 8'h40);
    foreach (ids[k])
      runCmd(8'hef, 8'h4a, ids[k], 8'h32, 16'h0100 + 16'(k));
    runCmd(8'hef, 8'h4a, 8'h82, 8'h22, 16'hffff);
    runCmd(8'hef, 8'h4a, 8'h00, 8'hb2, 16'd6553);
    runCmd(8'hef, 8'h4a, 8'h01, 8'hb2, 16'd6554);
    runCmd(8'hef, 8'h4a, 8'h81, 8'h32, 16'h0000);
    $display("timer tests done");
    runCmd(8'hef, 8'h4a, 8'h01, 8'h13, 16'h0);
    runCmd(8'hef, 8'h4a, 8'h82, 8'h33, 16'h0);
    runCmd(8'hef, 8'h4a, 8'h00, 8'h03, 16'h0);
    $display("state tests done");
    runCmd(8'hef, 8'h4a, 8'h81, 8'h01, 16'h0);
    runCmd(8'hef, 8'h4a, 8'hff, 8'h01, 16'h0);
    runCmd(8'hef, 8'h4a, 8'h82, 8'h01, 16'h0);
    runCmd(8'hef, 8'h4a, 8'h02, 8'h01, 16'h0);
    runCmd(8'hef, 8'h4a, 8'h01, 8'h04, 16'h0);
    runCmd(8'hef, 8'h05, 8'h01, 8'h02, 16'h5);
    runCmd(8'hb0, 8'h4a, 8'h01, 8'h02, 16'h5);
    $display("go-to tests done");
    @(posedge core_clk);
    epcEnabled <= 0;
    @(posedge core_clk);
    for (int k = 1; k < 4; k++)
      runCmd(8'hef, 8'h4a, 8'h01, 8'h20 | 8'(k), 16'h7);
    @(posedge core_clk);
    epcEnabled <= 1;
    @(posedge core_clk);
    $display("disabled tests done");
    repeat (12) begin
      lfsr = nextLfsr(lfsr);
      runCmd(8'hef, 8'h4a, ids[lfsr[1:0]], {lfsr[7], 1'b0, lfsr[5:4], 3'b001,
             lfsr[8]}, {lfsr[3:0], lfsr[15:4]});
    end
    $display("random tests done");
    apb(0, 12'h00c, 32'h0, r, e);
    check("unmapped error", e, 1);
    check("unmapped data", r, 0);
    @(posedge core_clk);
    rstn <= 0;
    repeat (6) @(posedge core_clk);
    rstn <= 1;
    mCt = '0;
    mSt = '0;
    mCe = '0;
    mSe = '0;
    runCmd(8'hef, 8'h4a, 8'h01, 8'h03, 16'h0);
    $display("reset tests done");
    repeat (4) @(posedge core_clk);
    complete_run();
  end
endmodule // power_condition_subcommands_tb
